/* File: design/sbt_dr_shift.sv */
// Capture and shift data register of the test port.
// Assumes strobes, enable and data all come from the test clock domain.
`timescale 1ns/1ns
module sbt_dr_shift
  import sbt_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         tck,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire sbt_dr_ctrl_s ctrl,
  input  wire logic [W-1:0] cap_val,
  input  wire logic         tdi,
  output logic              sout
);

  logic [W-1:0] shift_reg;

  // ****************************************
  // Capture then shift, bit 0 leaves first
  // ****************************************
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= '0;
    end else if (ce) begin
      if (ctrl.capture) begin
        shift_reg <= cap_val;
      end else if (ctrl.shift) begin
        shift_reg <= {tdi, shift_reg[W-1:1]};
      end
    end
  end

  assign sout = shift_reg[0];

endmodule // sbt_dr_shift

/* File: design/sbt_tap_port.sv */
// Boundary-scan test access port of the memory device.
// Assumes tck comes from the board controller and may stop at any time.
`timescale 1ns/1ns
module sbt_tap_port
  import sbt_pkg::*;
#(
  parameter int          BSR_LEN = BSR_LEN_DEF,
  // Arbitrary identification value
  parameter logic [31:0] ID_CODE = 32'h0a5a_5001
) (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic               clk_en,
  input  wire logic               tck,
  input  wire logic               tms_pin,
  input  wire logic               tms_drv,
  input  wire logic               tdi_pin,
  input  wire logic               tdi_drv,
  input  wire logic [BSR_LEN-1:0] pin_levels,
  output logic                    tdo_out,
  output logic                    tdo_oe,
  output logic [IR_W-1:0]         sys_instr,
  output logic                    sys_tap_reset
);

  // ****************************************
  // Declarations
  // ****************************************
  sbt_tap_state_e     state_reg, state_next;
  logic [IR_W-1:0]    ir_reg, ir_next, ir_shift_reg;
  logic               byp_reg, tdo_reg, tdo_oe_reg, tdo_src;
  logic               ce_s1_reg, ce_s2_reg;
  logic [BSR_LEN-1:0] pin_s1_reg, pin_s2_reg;
  logic               tlr_reg, ir_tgl_reg;
  logic               tms_eff, tdi_eff, in_shift;
  logic               id_sout, bsr_sout, bsr_sel;
  sbt_dr_ctrl_s       id_ctrl, bsr_ctrl;
  logic               rst_s1_reg, rst_s2_reg;
  logic [2:0]         tgl_s_reg;
  logic [IR_W-1:0]    sys_instr_reg;

  // ****************************************
  // Pin conditioning in the test clock domain
  // ****************************************
  // pull-up on select and data in
  assign tms_eff = tms_drv ? tms_pin : 1'b1;
  assign tdi_eff = tdi_drv ? tdi_pin : 1'b1;

  // Enable and pin levels cross in from other domains
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      ce_s1_reg <= 1'b0;
      ce_s2_reg <= 1'b0;
    end else begin
      ce_s1_reg <= clk_en;
      ce_s2_reg <= ce_s1_reg;
    end
  end

  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else if (ce_s2_reg) begin
      pin_s1_reg <= pin_levels;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ****************************************
  // Controller
  // ****************************************
  // select steers transitions
  always_comb begin
    unique case (state_reg)
      ST_TLR:    state_next = tms_eff ? ST_TLR    : ST_RTI;
      ST_RTI:    state_next = tms_eff ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_next = tms_eff ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_eff ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_next = tms_eff ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms_eff ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  state_next = tms_eff ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_next = tms_eff ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  state_next = tms_eff ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_next = tms_eff ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: state_next = tms_eff ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_next = tms_eff ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms_eff ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  state_next = tms_eff ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_next = tms_eff ? ST_UP_IR  : ST_SH_IR;
      ST_UP_IR:  state_next = tms_eff ? ST_SEL_DR : ST_RTI;
    endcase
  end

  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_TLR;
    end else if (ce_s2_reg) begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Instruction register
  // ****************************************
  // identification preload
  always_comb begin
    ir_next = ir_reg;
    if (state_reg == ST_TLR) begin
      ir_next = INS_IDCODE;
    end else if (state_reg == ST_UP_IR) begin
      ir_next = ir_shift_reg;
    end
  end

  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      ir_reg <= INS_IDCODE;
    end else if (ce_s2_reg) begin
      ir_reg <= ir_next;
    end
  end

  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      ir_shift_reg <= IR_CAPTURE;
    end else if (ce_s2_reg) begin
      if (state_reg == ST_CAP_IR) begin
        ir_shift_reg <= IR_CAPTURE;
      end else if (state_reg == ST_SH_IR) begin
        ir_shift_reg <= {tdi_eff, ir_shift_reg[IR_W-1:1]};
      end
    end
  end

  // ****************************************
  // Data registers
  // ****************************************
  // single bypass stage
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      byp_reg <= BYP_CAPTURE;
    end else if (ce_s2_reg) begin
      if (state_reg == ST_CAP_DR) begin
        byp_reg <= BYP_CAPTURE;
      end else if (state_reg == ST_SH_DR) begin
        byp_reg <= tdi_eff;
      end
    end
  end

  assign bsr_sel = (ir_reg == INS_EXTEST) || (ir_reg == INS_SAMPLE)
                || (ir_reg == INS_SAMPLE_Z);
  assign id_ctrl.capture  = (state_reg == ST_CAP_DR) && (ir_reg == INS_IDCODE);
  assign id_ctrl.shift    = (state_reg == ST_SH_DR) && (ir_reg == INS_IDCODE);
  assign bsr_ctrl.capture = (state_reg == ST_CAP_DR) && bsr_sel;
  assign bsr_ctrl.shift   = (state_reg == ST_SH_DR) && bsr_sel;

  sbt_dr_shift #(.W(ID_W)) u_id (
    .tck     (tck),
    .reset_n (reset_n),
    .ce      (ce_s2_reg),
    .ctrl    (id_ctrl),
    .cap_val (ID_CODE),
    .tdi     (tdi_eff),
    .sout    (id_sout)
  );

  sbt_dr_shift #(.W(BSR_LEN)) u_bsr (
    .tck     (tck),
    .reset_n (reset_n),
    .ce      (ce_s2_reg),
    .ctrl    (bsr_ctrl),
    .cap_val (pin_s2_reg),
    .tdi     (tdi_eff),
    .sout    (bsr_sout)
  );

  // ****************************************
  // Serial output
  // ****************************************
  // path from state and instruction
  always_comb begin
    tdo_src = byp_reg;
    if (state_reg == ST_SH_IR) begin
      tdo_src = ir_shift_reg[0];
    end else if (ir_reg == INS_IDCODE) begin
      tdo_src = id_sout;
    end else if (bsr_sel) begin
      tdo_src = bsr_sout;
    end
  end

  assign in_shift = (state_reg == ST_SH_DR) || (state_reg == ST_SH_IR);

  always_ff @(negedge tck or negedge reset_n) begin
    if (!reset_n) begin
      tdo_reg    <= TDO_RST;
      tdo_oe_reg <= 1'b0;
    end else if (ce_s2_reg) begin
      tdo_reg    <= in_shift ? tdo_src : TDO_RST;
      tdo_oe_reg <= in_shift;
    end
  end

  assign tdo_out = tdo_reg;
  assign tdo_oe  = tdo_oe_reg;

  // ****************************************
  // Status toward the memory clock domain
  // ****************************************
  // Toggle marks each instruction change; word holds for many tck cycles
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      tlr_reg    <= 1'b1;
      ir_tgl_reg <= 1'b0;
    end else if (ce_s2_reg) begin
      tlr_reg    <= (state_next == ST_TLR);
      ir_tgl_reg <= ir_tgl_reg ^ (ir_next != ir_reg);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_reg    <= 1'b1;
      rst_s2_reg    <= 1'b1;
      tgl_s_reg     <= '0;
      sys_instr_reg <= INS_IDCODE;
    end else if (clk_en) begin
      rst_s1_reg <= tlr_reg;
      rst_s2_reg <= rst_s1_reg;
      tgl_s_reg  <= {tgl_s_reg[1:0], ir_tgl_reg};
      if (tgl_s_reg[2] ^ tgl_s_reg[1]) begin
        sys_instr_reg <= ir_reg;
      end
    end
  end

  assign sys_instr     = sys_instr_reg;
  assign sys_tap_reset = rst_s2_reg;

  // ****************************************
  // Checks
  // ****************************************
  chk_five_ones_reset: assert property (
    @(posedge tck) disable iff (!reset_n || !ce_s2_reg)
    tms_eff [*5] |=> state_reg == ST_TLR)
    else $error("five select ones did not reach reset");

  chk_tms_pullup: assert property (
    @(posedge tck) disable iff (!reset_n || !ce_s2_reg)
    (!tms_drv) [*5] |=> state_reg == ST_TLR)
    else $error("undriven select did not act as one");

  chk_ir_preload: assert property (
    @(posedge tck) disable iff (!reset_n || !ce_s2_reg)
    state_reg == ST_TLR |=> ir_reg == INS_IDCODE)
    else $error("instruction not preloaded in reset");

  chk_ir_capture: assert property (
    @(posedge tck) disable iff (!reset_n || !ce_s2_reg)
    state_reg == ST_CAP_IR |=> ir_shift_reg[1:0] == 2'h1)
    else $error("capture pattern wrong");

  chk_ir_shift_in: assert property (
    @(posedge tck) disable iff (!reset_n || !ce_s2_reg)
    state_reg == ST_SH_IR |=> ir_shift_reg[2] == $past(tdi_eff))
    else $error("instruction shift lost input bit");

  chk_idle_stays: assert property (
    @(posedge tck) disable iff (!reset_n || !ce_s2_reg)
    state_reg == ST_RTI && !tms_eff |=> state_reg == ST_RTI ##1 1'b1)
    else $error("idle left without select high");

  chk_bypass_pullup: assert property (
    @(posedge tck) disable iff (!reset_n || !ce_s2_reg)
    state_reg == ST_SH_DR && ir_reg == INS_BYPASS && !tdi_drv
    |=> byp_reg)
    else $error("undriven data did not shift a one");

  chk_bypass_to_tdo: assert property (
    @(posedge tck) disable iff (!reset_n || !ce_s2_reg)
    state_reg == ST_SH_DR && ir_reg == INS_BYPASS && $past(in_shift)
    |-> tdo_reg == byp_reg)
    else $error("bypass bit not on serial output");

  chk_tdo_enable: assert property (
    @(posedge tck) disable iff (!reset_n || !ce_s2_reg)
    $past(ce_s2_reg) |-> tdo_oe_reg == in_shift)
    else $error("output enable outside shift states");

  chk_update_ir: assert property (
    @(posedge tck) disable iff (!reset_n || !ce_s2_reg)
    state_reg == ST_UP_IR |=> ir_reg == $past(ir_shift_reg))
    else $error("instruction not taken at update");

endmodule // sbt_tap_port

/* File: shared/sbt_pkg.sv */
// Constants, states and carrier types of the test access port.
// Assumes one port instance per device; no other package is used.
package sbt_pkg;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam int         IR_W         = 3;
  localparam logic [2:0] INS_EXTEST   = 3'h0;
  localparam logic [2:0] INS_IDCODE   = 3'h1;
  localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INS_SAMPLE   = 3'h4;
  localparam logic [2:0] INS_BYPASS   = 3'h7;
  // Pattern loaded at capture, low bits 01
  localparam logic [2:0] IR_CAPTURE   = 3'h1;

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic       BYP_CAPTURE  = 1'h0;
  localparam logic       TDO_RST      = 1'h0;
  localparam int         ID_W         = 32;
  localparam int         BSR_LEN_DEF  = 16;

  // ****************************************
  // Controller states
  // ****************************************
  typedef enum logic [3:0] {
    ST_TLR    = 4'h0, ST_RTI    = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR  = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR  = 4'h6, ST_EX2_DR = 4'h7,
    ST_UP_DR  = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR  = 4'hb,
    ST_EX1_IR = 4'hc, ST_PA_IR  = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR  = 4'hf
  } sbt_tap_state_e;

  // Data register strobes
  typedef struct packed {
    logic capture;
    logic shift;
  } sbt_dr_ctrl_s;

endpackage

/* File: verif/sbt_ctl_model.sv */
// Behavioural board test controller driving the test port link.
// Assumes the bench calls its tasks one at a time; tck rests low between frames.
`timescale 1ns/1ns
module sbt_ctl_model (
  output logic      tck,
  output logic      tms_pin,
  output logic      tdi_pin,
  input  wire logic tms_drv,
  input  wire logic tdi_drv,
  input  wire logic tdo_out,
  input  wire logic tdo_oe
);
  // ****************************************
  // Link cycles
  // ****************************************
  logic junk;

  initial begin
    tck     = 1'b0;
    tms_pin = 1'b1;
    tdi_pin = 1'b1;
    junk    = 1'b0;
  end

  // one link cycle
  // Undriven pins toggle so a design that reads them anyway is caught
  task automatic clk1(input logic m, input logic d, output logic o, output logic oe);
    junk    = ~junk;
    tms_pin = tms_drv ? m : junk;
    tdi_pin = tdi_drv ? d : junk;
    #80;
    o   = tdo_out;
    oe  = tdo_oe;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask

  task automatic go(input logic [7:0] seq, input int n);
    logic o;
    logic oe;
    for (int i = 0; i < n; i++) begin
      clk1(seq[i], 1'b1, o, oe);
    end
  endtask

  task automatic shift(input int n, input logic [63:0] din, output logic [63:0] dout,
                       output logic oe_all, output logic oe_aft);
    logic o;
    logic oe;
    dout   = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      clk1(i == n - 1, din[i], o, oe);
      dout[i] = o;
      oe_all  = oe_all & oe;
    end
    clk1(1'b1, 1'b1, o, oe);
    oe_aft = oe;
    clk1(1'b0, 1'b1, o, oe);
  endtask
endmodule // sbt_ctl_model

/* File: verif/tb.sv */
// Self-checking bench for the test access port.
// Assumes the controller model drives the link; bench drives the memory side.
`timescale 1ns/1ns
module tb;
  import sbt_pkg::*;
  localparam int          BLEN   = 16;
  // Arbitrary identification value
  localparam logic [31:0] ID_VAL = 32'h1234_5678;
  logic            clk_sys, reset_n, tck, tms_pin, tdi_pin, tms_drv, tdi_drv;
  logic            tdo_out, tdo_oe, sys_tap_reset, oe_all, oe_aft, clk_en;
  logic [BLEN-1:0] pins;
  logic [IR_W-1:0] sys_instr;
  logic [63:0]     din, dout, exp_v;
  logic [2:0]      codes [6];
  int              num_errors, tests_run, len;
  int              cyc = 0;

  sbt_tap_port #(.BSR_LEN(BLEN), .ID_CODE(ID_VAL)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .tck(tck),
    .tms_pin(tms_pin), .tms_drv(tms_drv), .tdi_pin(tdi_pin), .tdi_drv(tdi_drv),
    .pin_levels(pins), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .sys_instr(sys_instr), .sys_tap_reset(sys_tap_reset));

  sbt_ctl_model ctl_u (
    .tck(tck), .tms_pin(tms_pin), .tdi_pin(tdi_pin), .tms_drv(tms_drv),
    .tdi_drv(tdi_drv), .tdo_out(tdo_out), .tdo_oe(tdo_oe));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wsys(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Hang guard, well above the expected run of some 4300 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 50000) begin
      num_errors++;
      conclude();
    end
  end

  always @(tdo_out) begin
    if (reset_n === 1'b1) begin
      check("tdo_edge", tck, 1'b0);
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    num_errors = 0;
    tests_run  = 0;
    reset_n    = 1'b0;
    clk_en     = 1'b1;
    tms_drv    = 1'b1;
    tdi_drv    = 1'b1;
    pins       = '0;
    void'($urandom(32'h0000_18e7));
    codes = '{INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE, INS_IDCODE, 3'h3, INS_BYPASS};
    wsys(12);
    reset_n = 1'b1;
    check("instr_rst", sys_instr, INS_IDCODE);
    check("tlr_rst", sys_tap_reset, 1'b1);
    check("oe_rst", tdo_oe, 1'b0);
    $display("test reset done");
    ctl_u.go(8'hff, 8);
    ctl_u.go(8'h02, 4);
    din = {$urandom, $urandom};
    ctl_u.shift(32, din, dout, oe_all, oe_aft);
    check("id_word", dout[31:0], ID_VAL);
    check("oe_shift", {oe_all, oe_aft}, 2'b10);
    $display("test idcode done");
    foreach (codes[k]) begin
      @(negedge clk_sys);
      pins = BLEN'($urandom);
      ctl_u.go(8'h03, 4);
      ctl_u.shift(3, 64'(codes[k]), dout, oe_all, oe_aft);
      check("ir_capture", dout[2:0], IR_CAPTURE);
      wsys(8);
      check("instr", sys_instr, codes[k]);
      ctl_u.go(8'h01, 3);
      din = {$urandom, $urandom};
      case (codes[k])
        INS_IDCODE: begin
          len   = 32;
          exp_v = 64'(ID_VAL);
        end
        INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE: begin
          len   = BLEN;
          exp_v = 64'(pins);
        end
        default: begin
          len   = 8;
          exp_v = {56'h0, din[6:0], 1'b0};
        end
      endcase
      ctl_u.shift(len, din, dout, oe_all, oe_aft);
      check("dr_path", dout & ((64'h1 << len) - 1), exp_v);
    end
    $display("test instructions done");
    @(negedge clk_sys);
    tms_drv = 1'b0;
    ctl_u.go(8'h00, 5);
    @(negedge clk_sys);
    tms_drv = 1'b1;
    wsys(8);
    check("tlr_float", sys_tap_reset, 1'b1);
    check("instr_float", sys_instr, INS_IDCODE);
    $display("test floating mode select done");
    ctl_u.go(8'h06, 5);
    ctl_u.shift(3, 64'(INS_BYPASS), dout, oe_all, oe_aft);
    ctl_u.go(8'h01, 3);
    @(negedge clk_sys);
    tdi_drv = 1'b0;
    ctl_u.shift(8, 64'h0, dout, oe_all, oe_aft);
    check("tdi_float", dout[7:0], 8'hfe);
    @(negedge clk_sys);
    tdi_drv = 1'b1;
    $display("test floating data in done");
    // Enable low: two edges still act through the sync, the rest are frozen
    @(negedge clk_sys);
    clk_en = 1'b0;
    ctl_u.go(8'hff, 8);
    @(negedge clk_sys);
    clk_en = 1'b1;
    ctl_u.go(8'h00, 2);
    wsys(8);
    check("tlr_frozen", sys_tap_reset, 1'b0);
    check("instr_frozen", sys_instr, INS_BYPASS);
    $display("test clock enable done");
    conclude();
  end
endmodule // tb
